// ---- csm_pkg.sv ----
package csm_pkg;

   // status register bit positions
   localparam int BIT_C      = 0;
   localparam int BIT_Z      = 1;
   localparam int BIT_N      = 2;
   localparam int BIT_GIE    = 3;
   localparam int BIT_CORE_HALT_BIT = 4;
   localparam int BIT_CRYSTAL_STOP_BIT = 5;
   localparam int BIT_LOOP_CONTROL_SHUTDOWN   = 6;
   localparam int BIT_DCO_DC_GEN_SHUTDOWN   = 7;
   localparam int BIT_V      = 8;

   // value after reset and writable mask
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] STATUS_MASK  = 16'h01ff;

   // register indices
   localparam logic [3:0] REG_PC    = 4'h0;
   localparam logic [3:0] REG_SP    = 4'h1;
   localparam logic [3:0] REG_SR    = 4'h2;
   localparam logic [3:0] REG_CG    = 4'h3;
   localparam logic [3:0] REG_FIRST = 4'h4;

   // source and destination mode codes
   localparam logic [1:0] AS_REG   = 2'h0;
   localparam logic [1:0] AS_IDX   = 2'h1;
   localparam logic [1:0] AS_IND   = 2'h2;
   localparam logic [1:0] AS_AUTO  = 2'h3;
   localparam logic       AD_REG   = 1'b0;
   localparam logic       AD_IDX   = 1'b1;

   // generated constants
   localparam logic [15:0] CONST_ZERO = 16'h0000;
   localparam logic [15:0] CONST_ONE  = 16'h0001;
   localparam logic [15:0] CONST_TWO  = 16'h0002;
   localparam logic [15:0] CONST_FOUR = 16'h0004;
   localparam logic [15:0] CONST_EIGHT = 16'h0008;
   localparam logic [15:0] CONST_ONES = 16'hffff;

   // autoincrement steps
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;

   // alu operation codes
   typedef enum logic [2:0] {
      OP_MOV,
      OP_ADD,
      OP_ADDC,
      OP_SUB,
      OP_SUBC,
      OP_CMP,
      OP_LOGIC
   } csm_op_type;

   // operand location kinds
   typedef enum logic [2:0] {
      LOC_REG,
      LOC_MEM,
      LOC_CONST
   } csm_loc_type;

endpackage

// ---- csm_rf_if.sv ----
`timescale 1ns/1ps
interface csm_rf_if;
   import csm_pkg::*;
   logic [3:0]  rd_a_addr;
   logic [15:0] rd_a_data;
   logic [3:0]  rd_b_addr;
   logic [15:0] rd_b_data;
   logic        wr_en;
   logic [3:0]  wr_addr;
   logic [15:0] wr_data;
   logic        inc_en;
   logic [3:0]  inc_addr;
   logic [15:0] inc_step;

   modport core (
      output rd_a_addr,
      input  rd_a_data,
      output rd_b_addr,
      input  rd_b_data,
      output wr_en,
      output wr_addr,
      output wr_data,
      output inc_en,
      output inc_addr,
      output inc_step
   );
   modport store (
      input  rd_a_addr,
      output rd_a_data,
      input  rd_b_addr,
      output rd_b_data,
      input  wr_en,
      input  wr_addr,
      input  wr_data,
      input  inc_en,
      input  inc_addr,
      input  inc_step
   );
endinterface

// ---- csm_gpr_mem.sv ----
`timescale 1ns/1ps
module csm_gpr_mem
   import csm_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic clk_en,
   csm_rf_if.store   rf
);

   logic [15:0] regs      [16];
   logic [15:0] next_regs [16];
   logic [15:0] rd_a;
   logic [15:0] rd_b;
   logic [15:0] next_rd_a;
   logic [15:0] next_rd_b;

   // write port wins over increment on the same register
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         next_regs[i] = regs[i];
      end
      if (rf.inc_en && rf.inc_addr >= REG_FIRST) begin
         next_regs[rf.inc_addr] = regs[rf.inc_addr] + rf.inc_step;
      end
      if (rf.wr_en && rf.wr_addr >= REG_FIRST) begin
         next_regs[rf.wr_addr] = rf.wr_data;
      end
      next_rd_a = next_regs[rf.rd_a_addr];
      next_rd_b = next_regs[rf.rd_b_addr];
   end

   // storage and registered read data
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 16; i++) begin
            regs[i] <= 16'h0000;
         end
         rd_a <= 16'h0000;
         rd_b <= 16'h0000;
      end else if (clk_en) begin
         regs <= next_regs;
         rd_a <= next_rd_a;
         rd_b <= next_rd_b;
      end
   end

   assign rf.rd_a_data = rd_a;
   assign rf.rd_b_data = rd_b;

endmodule

// ---- csm_status_core.sv ----
`timescale 1ns/1ps
// What this block does
// RULE_01: status register direct only in word register mode
// RULE_02: add overflow from same-sign operands, sign change
// RULE_03: subtract overflow from opposite-sign operands, sign change
// RULE_04: dc generator off unless feeding system clocks
// RULE_05: loop control disabled when its bit set
// RULE_06: crystal stopped unless feeding system clocks
// RULE_07: processor off bit halts the core
// RULE_08: maskable interrupts pass only with enable set
// RULE_09: negative flag from bit 15 or 7
// RULE_10: zero flag set on zero result
// RULE_11: carry flag follows operation carry out
// RULE_12: six constants from registers two and three
// RULE_13: constant registers are source only
// RULE_14: register three mode 00 gives zero
// RULE_15: registers four to fifteen byte or word
// RULE_16: decode source and destination mode fields
// RULE_17: symbolic is indexed on program counter
// RULE_18: absolute is indexed with zero base
// RULE_19: autoincrement adds one byte, two word
// RULE_20: immediate is autoincrement on program counter
// RULE_21: seven source modes, four destination modes
// RULE_22: any source and destination pairing accepted
// RULE_23: byte register write clears upper byte
// RULE_24: constant table per register and mode
module csm_status_core
   import csm_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   input  wire logic        instr_valid,
   input  wire csm_op_type  alu_op,
   input  wire logic        byte_op,
   input  wire logic [3:0]  src_reg,
   input  wire logic [1:0]  source_mode_field,
   input  wire logic [3:0]  dst_reg,
   input  wire logic        dst_mode,
   input  wire logic [15:0] ext_word_src,
   input  wire logic [15:0] ext_word_dst,
   input  wire logic [15:0] pc_value,
   input  wire logic [15:0] mem_src_data,
   input  wire logic [15:0] mem_dst_data,
   input  wire logic [15:0] logic_result,
   input  wire logic        logic_flags_en,
   input  wire logic        irq_request,
   input  wire logic        dco_feeds_sys_clk,
   input  wire logic        xtal_feeds_sys_clk,
   output logic [15:0]      processor_status_flags,
   output logic [15:0]      src_operand,
   output logic [15:0]      src_address,
   output logic             src_from_mem,
   output logic [15:0]      dst_address,
   output logic             dst_to_mem,
   output logic [15:0]      result_data,
   output logic             pc_step_src,
   output logic             core_halt,
   output logic             irq_accept,
   output logic             dco_dc_gen_off,
   output logic             loop_control_off,
   output logic             crystal_off,
   output logic             const_used
);

   csm_rf_if rf ();

   csm_gpr_mem u_mem (
      .ref_clk (ref_clk),
      .reset   (reset),
      .clk_en  (clk_en),
      .rf      (rf.store)
   );

   logic        is_const;
   logic [15:0] const_val;
   logic        sr_direct;
   logic [15:0] sreg_val;
   logic [15:0] dreg_val;
   logic [15:0] src_val;
   logic [15:0] dst_val;
   logic [15:0] sbase;
   logic [15:0] dbase;
   logic [16:0] sum;
   logic [15:0] res;
   logic        msb_a;
   logic        msb_b;
   logic        msb_r;
   logic        carry;
   logic        arith;
   logic        writes_dst;
   logic [15:0] next_status;
   logic [15:0] next_src_operand;
   logic [15:0] next_src_address;
   logic        next_src_from_mem;
   logic [15:0] next_dst_address;
   logic        next_dst_to_mem;
   logic [15:0] next_result_data;
   logic        next_pc_step_src;
   logic        next_const_used;

   // register file addressing; data arrive one cycle later
   assign rf.rd_a_addr = src_reg;
   assign rf.rd_b_addr = dst_reg;

   // pick register or special values for the current operands
   always_comb begin
      sreg_val = rf.rd_a_data;
      if (src_reg == REG_PC) begin
         sreg_val = pc_value;
      end else if (src_reg == REG_SR) begin
         sreg_val = processor_status_flags;
      end
      dreg_val = rf.rd_b_data;
      if (dst_reg == REG_PC) begin
         dreg_val = pc_value;
      end else if (dst_reg == REG_SR) begin
         dreg_val = processor_status_flags;
      end
   end

   // constant generator on registers two and three
   always_comb begin
      is_const  = 1'b0;
      const_val = CONST_ZERO;
      sr_direct = (source_mode_field == AS_REG) && !byte_op;       // RULE_01
      if (src_reg == REG_CG) begin                                  // RULE_12
         is_const = 1'b1;                                           // RULE_13
         case (source_mode_field)
            AS_REG:  const_val = CONST_ZERO;                        // RULE_14
            AS_IDX:  const_val = CONST_ONE;                         // RULE_24
            AS_IND:  const_val = CONST_TWO;
            default: const_val = CONST_ONES;
         endcase
      end else if (src_reg == REG_SR && !sr_direct) begin           // RULE_01
         case (source_mode_field)
            AS_IND: begin
               is_const  = 1'b1;
               const_val = CONST_FOUR;                              // RULE_24
            end
            AS_AUTO: begin
               is_const  = 1'b1;
               const_val = CONST_EIGHT;
            end
            default: is_const = 1'b0;                               // RULE_18
         endcase
      end
   end

   // source and destination operand decode
   always_comb begin
      sbase             = (src_reg == REG_SR) ? 16'h0000 : sreg_val;   // RULE_18
      dbase             = (dst_reg == REG_SR) ? 16'h0000 : dreg_val;   // RULE_18
      next_src_address  = 16'h0000;
      next_src_from_mem = 1'b0;
      next_pc_step_src  = 1'b0;
      src_val           = sreg_val;
      if (is_const) begin
         src_val = const_val;                                       // RULE_12
      end else begin
         case (source_mode_field)                                   // RULE_16 RULE_21
            AS_REG: begin
               src_val = sreg_val;                                  // RULE_15
            end
            AS_IDX: begin
               next_src_address  = sbase + ext_word_src;            // RULE_17
               next_src_from_mem = 1'b1;
               next_pc_step_src  = 1'b1;
               src_val           = mem_src_data;
            end
            AS_IND: begin
               next_src_address  = sreg_val;
               next_src_from_mem = 1'b1;
               src_val           = mem_src_data;
            end
            default: begin
               next_src_address  = sreg_val;                        // RULE_20
               next_src_from_mem = 1'b1;
               next_pc_step_src  = (src_reg == REG_PC);
               src_val           = mem_src_data;
            end
         endcase
      end
      if (byte_op) begin
         src_val = {8'h00, src_val[7:0]};
      end
      next_dst_to_mem  = (dst_mode == AD_IDX);                      // RULE_22
      next_dst_address = (dst_mode == AD_IDX) ? dbase + ext_word_dst : 16'h0000;
      dst_val          = (dst_mode == AD_IDX) ? mem_dst_data : dreg_val;
      // byte ops see only the low byte, so the carry comes out of bit 7
      if (byte_op) begin
         dst_val = {8'h00, dst_val[7:0]};                           // RULE_23
      end
   end

   // autoincrement of the pointer register
   assign rf.inc_en   = instr_valid && clk_en && !is_const && !core_halt
                        && source_mode_field == AS_AUTO;
   assign rf.inc_addr = src_reg;
   assign rf.inc_step = byte_op ? STEP_BYTE : STEP_WORD;           // RULE_19

   // arithmetic result and flag sources
   always_comb begin
      arith = 1'b1;
      carry = 1'b0;
      sum   = 17'h00000;
      case (alu_op)
         OP_ADD:  sum = {1'b0, dst_val} + {1'b0, src_val};
         OP_ADDC: sum = {1'b0, dst_val} + {1'b0, src_val}
                        + {16'h0000, processor_status_flags[BIT_C]};
         OP_SUB,
         OP_CMP:  sum = {1'b0, dst_val} + {1'b0, ~src_val} + 17'h00001;
         OP_SUBC: sum = {1'b0, dst_val} + {1'b0, ~src_val}
                        + {16'h0000, processor_status_flags[BIT_C]};
         OP_LOGIC: begin
            sum   = {1'b0, logic_result};
            arith = 1'b0;
         end
         default: begin
            sum   = {1'b0, src_val};
            arith = 1'b0;
         end
      endcase
      res   = sum[15:0];
      if (byte_op) begin
         res   = {8'h00, sum[7:0]};                                 // RULE_23
         carry = sum[8];                                            // RULE_11
         msb_a = dst_val[7];
         msb_b = src_val[7];
         msb_r = res[7];                                            // RULE_09
         if (alu_op inside {OP_SUB, OP_SUBC, OP_CMP}) begin
            carry = ({1'b0, dst_val[7:0]} + {1'b0, ~src_val[7:0]}
                     + ((alu_op == OP_SUBC) ? {8'h00, processor_status_flags[BIT_C]}
                                            : 9'h001)) >> 8 != 9'h000;
         end else if (alu_op == OP_ADDC) begin
            carry = ({1'b0, dst_val[7:0]} + {1'b0, src_val[7:0]}
                     + {8'h00, processor_status_flags[BIT_C]}) >> 8 != 9'h000;
         end
      end else begin
         carry = sum[16];                                           // RULE_11
         msb_a = dst_val[15];
         msb_b = src_val[15];
         msb_r = res[15];                                           // RULE_09
      end
   end

   // status register next state
   always_comb begin
      next_status = processor_status_flags;
      writes_dst  = instr_valid && alu_op != OP_CMP;
      if (instr_valid && !core_halt) begin
         if (arith || (alu_op == OP_LOGIC && logic_flags_en)) begin
            next_status[BIT_N] = msb_r;                             // RULE_09
            next_status[BIT_Z] = (res == 16'h0000);                 // RULE_10
            next_status[BIT_C] = arith ? carry : (res != 16'h0000);
            next_status[BIT_V] = 1'b0;
            if (alu_op inside {OP_ADD, OP_ADDC}) begin
               next_status[BIT_V] = (msb_a == msb_b) && (msb_r != msb_a);   // RULE_02
            end else if (alu_op inside {OP_SUB, OP_SUBC, OP_CMP}) begin
               next_status[BIT_V] = (msb_a != msb_b) && (msb_r != msb_a);   // RULE_03
            end
         end
         // explicit write into status register, word register mode only
         if (writes_dst && dst_reg == REG_SR && dst_mode == AD_REG && !byte_op) begin
            next_status = res & STATUS_MASK;                        // RULE_01
         end
      end
   end

   // register file writeback for general registers
   assign rf.wr_en   = writes_dst && clk_en && !core_halt && dst_mode == AD_REG
                       && dst_reg >= REG_FIRST;                     // RULE_15
   assign rf.wr_addr = dst_reg;
   assign rf.wr_data = res;                                         // RULE_23

   // operand outputs
   always_comb begin
      next_src_operand = src_val;
      next_result_data = res;
      next_const_used  = is_const;
   end

   // status and operand registers
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         processor_status_flags <= STATUS_RESET;
         src_operand            <= 16'h0000;
         src_address            <= 16'h0000;
         src_from_mem           <= 1'b0;
         dst_address            <= 16'h0000;
         dst_to_mem             <= 1'b0;
         result_data            <= 16'h0000;
         pc_step_src            <= 1'b0;
         const_used             <= 1'b0;
      end else if (clk_en) begin
         processor_status_flags <= next_status;
         src_operand            <= next_src_operand;
         src_address            <= next_src_address;
         src_from_mem           <= next_src_from_mem;
         dst_address            <= next_dst_address;
         dst_to_mem             <= next_dst_to_mem;
         result_data            <= next_result_data;
         pc_step_src            <= next_pc_step_src;
         const_used             <= next_const_used;
      end
   end

   // control outputs from status bits
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         core_halt        <= 1'b0;
         irq_accept       <= 1'b0;
         dco_dc_gen_off   <= 1'b0;
         loop_control_off <= 1'b0;
         crystal_off      <= 1'b0;
      end else if (clk_en) begin
         core_halt        <= next_status[BIT_CORE_HALT_BIT];                         // RULE_07
         irq_accept       <= irq_request && next_status[BIT_GIE];             // RULE_08
         dco_dc_gen_off   <= next_status[BIT_DCO_DC_GEN_SHUTDOWN] && !dco_feeds_sys_clk;     // RULE_04
         loop_control_off <= next_status[BIT_LOOP_CONTROL_SHUTDOWN];                           // RULE_05
         crystal_off      <= next_status[BIT_CRYSTAL_STOP_BIT] && !xtal_feeds_sys_clk;  // RULE_06
      end
   end

endmodule

// ---- csm_status_core_assertions.sv ----
`timescale 1ns/1ps
module csm_status_core_assertions
   import csm_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic        clk_en,
   input wire logic [3:0]  src_reg,
   input wire logic [1:0]  source_mode_field,
   input wire logic        irq_request,
   input wire logic        dco_feeds_sys_clk,
   input wire logic        xtal_feeds_sys_clk,
   input wire logic [15:0] processor_status_flags,
   input wire logic [15:0] src_operand,
   input wire logic        core_halt,
   input wire logic        irq_accept,
   input wire logic        dco_dc_gen_off,
   input wire logic        loop_control_off,
   input wire logic        crystal_off,
   input wire logic        const_used
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // control outputs follow the status bits
   a_halt_from_status: assert property (core_halt == processor_status_flags[BIT_CORE_HALT_BIT])
      else $error("core halt differs from status");
   a_loop_ctrl_off: assert property (loop_control_off == processor_status_flags[BIT_LOOP_CONTROL_SHUTDOWN])
      else $error("loop control off differs from status");
   a_dco_gen_off: assert property (!$past(reset) && $past(clk_en) |->
      dco_dc_gen_off == (processor_status_flags[BIT_DCO_DC_GEN_SHUTDOWN] && !$past(dco_feeds_sys_clk)))
      else $error("dc generator off wrong");
   a_crystal_stop: assert property (!$past(reset) && $past(clk_en) |->
      crystal_off == (processor_status_flags[BIT_CRYSTAL_STOP_BIT] && !$past(xtal_feeds_sys_clk)))
      else $error("crystal off wrong");
   a_irq_gated: assert property (irq_accept |-> processor_status_flags[BIT_GIE] && $past(irq_request))
      else $error("interrupt accepted while masked");
   a_status_unused_zero: assert property ((processor_status_flags & ~STATUS_MASK) == 16'h0000)
      else $error("unused status bits set");
   a_halt_freezes: assert property (core_halt |=> $stable(processor_status_flags))
      else $error("status changed while halted");
   a_const_one: assert property (!$past(reset) && $past(clk_en) && !$past(core_halt) &&
      $past(src_reg) == REG_CG && $past(source_mode_field) == AS_IDX |-> src_operand == 16'h0001 && const_used)
      else $error("constant one wrong");
   a_const_four: assert property (!$past(reset) && $past(clk_en) && !$past(core_halt) &&
      $past(src_reg) == REG_SR && $past(source_mode_field) == AS_IND |-> src_operand == 16'h0004 && const_used)
      else $error("constant four wrong");
   c_irq_taken: cover property (irq_accept);
   c_const_used: cover property (const_used);
   c_core_halt: cover property (core_halt);
endmodule
bind csm_status_core csm_status_core_assertions u_chk (.*);

// ---- csm_bus_model.sv ----
`timescale 1ns/1ps
// operand bus: memory operands only while armed
module csm_bus_model
(
   input  wire logic        ref_clk,
   input  wire logic        arm,
   input  wire logic [15:0] src_val,
   input  wire logic [15:0] dst_val,
   output logic [15:0]      mem_src_data,
   output logic [15:0]      mem_dst_data
);
   logic [15:0] junk;
   // released bus shows a pattern changing every cycle
   initial junk = 16'h5a5a;
   always @(posedge ref_clk) begin
      junk <= {junk[14:0], ~junk[15]};
   end
   assign mem_src_data = arm ? src_val : junk;
   assign mem_dst_data = arm ? dst_val : ~junk;
endmodule

// ---- cpu_status_and_operand_modes_tb_top.sv ----
`timescale 1ns/1ps
module cpu_status_and_operand_modes_tb_top
   import csm_pkg::*;
   ;
   logic ref_clk = 0, reset, clk_en, instr_valid, byte_op, dst_mode, arm;
   logic logic_flags_en, irq_request, dco_feeds_sys_clk, xtal_feeds_sys_clk;
   csm_op_type alu_op;
   logic [3:0] src_reg, dst_reg;
   logic [1:0] source_mode_field;
   logic [15:0] ext_word_src, ext_word_dst, pc_value, mem_src_data, mem_dst_data;
   logic [15:0] logic_result, sv, dv, processor_status_flags, src_operand, src_address;
   logic [15:0] dst_address, result_data, exp_sr, v, s, d;
   logic src_from_mem, dst_to_mem, pc_step_src, core_halt, irq_accept;
   logic dco_dc_gen_off, loop_control_off, crystal_off, const_used, bw;
   logic [19:0] e;
   csm_op_type op;
   int mismatches = 0, cmp_count = 0;
   logic [15:0] ct_val [6] = '{16'h0000, 16'h0001, 16'h0002, 16'hffff, 16'h0004, 16'h0008};

   csm_status_core u_dut (.*);
   csm_bus_model u_bus (.ref_clk(ref_clk), .arm(arm), .src_val(sv), .dst_val(dv),
                        .mem_src_data(mem_src_data), .mem_dst_data(mem_dst_data));

   // 250 MHz clock
   always #2 ref_clk = ~ref_clk;

   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
      cmp_count++;
      if (got !== ex) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // one instruction: fields, then commit cycle, sample after the commit edge
   task automatic exec(input csm_op_type o, input logic b, input logic [3:0] sr_n,
         input logic [1:0] sm, input logic [3:0] dr, input logic dm,
         input logic [15:0] es, input logic [15:0] ed, input logic [15:0] ms,
         input logic [15:0] md);
      @(negedge ref_clk);
      alu_op = o;
      byte_op = b;
      src_reg = sr_n;
      source_mode_field = sm;
      dst_reg = dr;
      dst_mode = dm;
      ext_word_src = es;
      ext_word_dst = ed;
      sv = ms;
      dv = md;
      arm = 1'b1;
      @(negedge ref_clk);
      instr_valid = 1'b1;
      @(negedge ref_clk);
      instr_valid = 1'b0;
      arm = 1'b0;
   endtask

   // explicit status write, word register destination
   task automatic wr_sr(input logic [15:0] val);
      exec(OP_MOV, 1'b0, REG_SR, AS_IDX, REG_SR, AD_REG, 16'h0200, 16'h0000, val, 16'h0000);
      exp_sr = val & 16'h01ff;
      chk("status", exp_sr, processor_status_flags);
   endtask

   // expected {v,n,z,c,result} of add and subtract kinds
   function automatic logic [19:0] alu_exp(input csm_op_type o, input logic b,
         input logic [15:0] s_i, input logic [15:0] d_i, input logic cin);
      logic [16:0] t;
      logic [15:0] se, r;
      logic ci, n, c, ov;
      se = (o == OP_SUB || o == OP_SUBC || o == OP_CMP) ? ~s_i : s_i;
      ci = (o == OP_ADD) ? 1'b0 : (o == OP_SUB || o == OP_CMP) ? 1'b1 : cin;
      if (b) begin
         t = {9'h000, d_i[7:0]} + {9'h000, se[7:0]} + {16'h0000, ci};
         r = {8'h00, t[7:0]};
         n = t[7];
         c = t[8];
         ov = (d_i[7] == se[7]) && (t[7] != d_i[7]);
      end else begin
         t = {1'b0, d_i} + {1'b0, se} + {16'h0000, ci};
         r = t[15:0];
         n = t[15];
         c = t[16];
         ov = (d_i[15] == se[15]) && (t[15] != d_i[15]);
      end
      return {ov, n, r == 16'h0000, c, r};
   endfunction

   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      end_of_test();
   end

   initial begin
      void'($urandom(32006));
      {reset, clk_en, instr_valid, byte_op, dst_mode, arm} = 6'b110000;
      {logic_flags_en, irq_request, dco_feeds_sys_clk, xtal_feeds_sys_clk} = 4'h0;
      {src_reg, dst_reg, source_mode_field} = 10'h000;
      {ext_word_src, ext_word_dst, sv, dv, logic_result} = '0;
      alu_op = OP_MOV;
      pc_value = 16'h4000;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      chk("status_rst", 16'h0000, processor_status_flags);
      // clock control and interrupt bits, halt bit kept clear
      for (int k = 0; k < 10; k++) begin
         v = (k == 0) ? 16'hffef : (k == 1) ? 16'h0000 : 16'($urandom()) & 16'hffef;
         {dco_feeds_sys_clk, xtal_feeds_sys_clk, irq_request} = 3'($urandom());
         wr_sr(v);
         chk("irq_accept", 16'(v[3] & irq_request), 16'(irq_accept));
         chk("dco_off", 16'(v[7] & ~dco_feeds_sys_clk), 16'(dco_dc_gen_off));
         chk("loop_off", 16'(v[6]), 16'(loop_control_off));
         chk("xtal_off", 16'(v[5] & ~xtal_feeds_sys_clk), 16'(crystal_off));
      end
      exec(OP_MOV, 1'b1, REG_SR, AS_IDX, REG_SR, AD_REG, 16'h0200, 16'h0, 16'h00ff, 16'h0);
      chk("status_byte", exp_sr, processor_status_flags);
      wr_sr(16'h0000);
      // arithmetic flags, absolute source and destination
      for (int k = 0; k < 30; k++) begin
         op = csm_op_type'(3'($urandom_range(5, 1)));
         bw = 1'($urandom());
         s = 16'($urandom());
         d = 16'($urandom());
         if (k == 0) {op, bw, s, d} = {OP_ADD, 1'b0, 16'h7fff, 16'h0001};
         if (k == 1) {op, bw, s, d} = {OP_SUB, 1'b0, 16'h0001, 16'h8000};
         if (k == 2) {op, bw, s, d} = {OP_CMP, 1'b1, 16'h1280, 16'h3480};
         if (k == 3) {op, bw, s, d} = {OP_ADDC, 1'b1, 16'h00ff, 16'h0001};
         e = alu_exp(op, bw, s, d, exp_sr[0]);
         v = 16'($urandom());
         exec(op, bw, REG_SR, AS_IDX, REG_SR, AD_IDX, v, ~v, s, d);
         {exp_sr[8], exp_sr[2], exp_sr[1], exp_sr[0]} = e[19:16];
         chk("flags", exp_sr, processor_status_flags);
         if (op != OP_CMP) chk("result", e[15:0], result_data);
         chk("src_addr_abs", v, src_address);
         chk("dst_addr_abs", ~v, dst_address);
         chk("mem_flags", 16'h0003, {14'h0, src_from_mem, dst_to_mem});
      end
      // logic result with flag update: c is result nonzero, v cleared
      logic_flags_en = 1'b1;
      logic_result = 16'h8001;
      exec(OP_LOGIC, 1'b0, REG_SR, AS_IDX, REG_SR, AD_IDX, 16'h0, 16'h0, 16'h0, 16'h0);
      {exp_sr[8], exp_sr[2], exp_sr[1], exp_sr[0]} = 4'b0101;
      chk("logic_flags", exp_sr, processor_status_flags);
      logic_flags_en = 1'b0;
      // constant registers refuse writes, then the constant table
      exec(OP_MOV, 1'b0, REG_SR, AS_IDX, REG_CG, AD_REG, 16'h0200, 16'h0, 16'h1234, 16'h0);
      for (int k = 0; k < 6; k++) begin
         exec(OP_MOV, 1'b0, (k < 4) ? REG_CG : REG_SR, 2'(k < 4 ? k : k - 2), REG_SR, AD_IDX,
              16'h0, 16'h0300, 16'h0, 16'h0);
         chk("const", ct_val[k], src_operand);
         chk("const_used", 16'h0001, 16'(const_used));
      end
      // working registers, byte write and autoincrement
      exec(OP_MOV, 1'b0, REG_SR, AS_AUTO, 4'h4, AD_REG, 16'h0, 16'h0, 16'h0, 16'h0);
      exec(OP_MOV, 1'b1, REG_SR, AS_IDX, 4'h5, AD_REG, 16'h0200, 16'h0, 16'habcd, 16'h0);
      chk("byte_write", 16'h00cd, result_data);
      exec(OP_MOV, 1'b0, 4'h5, AS_REG, REG_SR, AD_IDX, 16'h0, 16'h0300, 16'h0, 16'h0);
      chk("reg_read", 16'h00cd, src_operand);
      for (int k = 0; k < 3; k++) begin
         exec(OP_MOV, k < 2, 4'h4, AS_AUTO, REG_SR, AD_IDX, 16'h0, 16'h0300, 16'h0, 16'h0);
         chk("autoinc", 16'h0008 + 16'(k), src_address);
      end
      exec(OP_MOV, 1'b0, 4'h4, AS_IDX, REG_SR, AD_IDX, 16'h0100, 16'h0300, 16'h0, 16'h0);
      chk("indexed", 16'h010c, src_address);
      exec(OP_MOV, 1'b0, REG_PC, AS_IDX, REG_SR, AD_IDX, 16'h0010, 16'h0300, 16'h0, 16'h0);
      chk("symbolic", 16'h4010, src_address);
      exec(OP_MOV, 1'b0, REG_PC, AS_AUTO, REG_SR, AD_IDX, 16'h0, 16'h0300, 16'h0, 16'h0);
      chk("immediate", 16'h4000, src_address);
      chk("pc_step", 16'h0001, 16'(pc_step_src));
      // halt freezes execution until reset
      wr_sr(16'h0018);
      chk("halt", 16'h0001, 16'(core_halt));
      exec(OP_ADD, 1'b0, REG_SR, AS_IDX, REG_SR, AD_IDX, 16'h0, 16'h0, 16'hffff, 16'h0001);
      chk("halted_flags", exp_sr, processor_status_flags);
      @(negedge ref_clk);
      reset = 1'b1;
      @(negedge ref_clk);
      reset = 1'b0;
      chk("status_rst2", 16'h0000, processor_status_flags);
      chk("halt_rst", 16'h0000, 16'(core_halt));
      end_of_test();
   end
endmodule
